/* burst4_pkg.sv */
// Shared constants and types for the burst-of-four common-I/O memory link.
// Assumes one system clock; each clock cycle stands for one half period of the
// link's input clock, so input-clock and complement-clock edges alternate.
package burst4_pkg;

  // Data path of the 18-bit variant: two 9-bit lanes
  localparam int DATA_W        = 18;
  localparam int LANE_W        = 9;
  localparam int LANES         = 2;
  // Narrow variants hide the two lowest address bits
  localparam bit NARROW_VARIANT = 1'b0;
  // Burst shape
  localparam int BEATS         = 4;
  localparam int BEAT_W        = 2;
  // Address space held by the model memory
  localparam int ADDR_W        = 6;
  localparam int WORDS         = 64;
  // Read pipeline wait loaded at capture, in half periods
  localparam logic [1:0] READ_WAIT_INIT = 2'h1;
  // Reset values
  localparam logic [DATA_W-1:0] DQ_RESET   = 18'h00000;
  localparam logic [LANES-1:0]  LANES_OFF  = 2'h3;

  // Device read send engine
  typedef enum logic [1:0] {
    SEND_IDLE  = 2'b01,
    SEND_BURST = 2'b10
  } send_state_t;

  // Controller sequencer
  typedef enum logic [3:0] {
    CTL_IDLE  = 4'b0001,
    CTL_CMD   = 4'b0010,
    CTL_WBEAT = 4'b0100,
    CTL_RWAIT = 4'b1000
  } ctl_state_t;

  // Word index of one beat inside a burst; narrow parts start at offset zero
  function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [BEAT_W-1:0] beat);
    logic [BEAT_W-1:0] low;
    low = NARROW_VARIANT ? beat : BEAT_W'(base[BEAT_W-1:0] + beat);
    return {base[ADDR_W-1:BEAT_W], low};
  endfunction

endpackage

/* burst4_link_if.sv */
// Pin-level link between the memory controller and the memory device.
// The shared data bus is split into per-side data and enable; the resolved
// level is formed here from whichever side drives.
`timescale 1ns/1ps
interface burst4_link_if;
  import burst4_pkg::*;

  logic                  input_clock;          // Input clock level, high = true phase
  logic                  out_clk_hold_high;    // Both output clocks held high
  logic                  out_clk_fire;         // Output clock edge strobe
  logic                  load_command_n;       // Load command, active low
  logic                  read_not_write;       // High read, low write
  logic [ADDR_W-1:0]     sync_address_bus;     // Burst base address
  logic [LANES-1:0]      byte_lane_enable_n;   // Lane write enables, active low
  logic                  loop_disable_n;       // Loop disable, active low
  logic [DATA_W-1:0]     dq_ctrl;              // Controller data out
  logic                  dq_ctrl_oe;           // Controller drives bus
  logic [DATA_W-1:0]     dq_mem;               // Memory data out
  logic                  dq_mem_oe;            // Memory drives bus
  logic                  echo_clock_out;       // Echo clock from memory
  logic [DATA_W-1:0]     dq_bus;               // Resolved bus level

  // Memory wins only when it drives; idle bus reads as the controller value
  assign dq_bus = dq_mem_oe ? dq_mem : dq_ctrl;

  modport memory (
    input  input_clock, out_clk_hold_high, out_clk_fire, load_command_n, read_not_write,
    input  sync_address_bus, byte_lane_enable_n, loop_disable_n, dq_bus,
    output dq_mem, dq_mem_oe, echo_clock_out
  );

  modport controller (
    output input_clock, out_clk_hold_high, out_clk_fire, load_command_n, read_not_write,
    output sync_address_bus, byte_lane_enable_n, loop_disable_n, dq_ctrl, dq_ctrl_oe,
    input  dq_bus, dq_mem_oe, echo_clock_out
  );
endinterface

/* burst4_memory.sv */
// Memory end of the burst-of-four link: command capture, late-write
// collection with lane masks, and pipelined four-beat reads.
// Assumes the controller drives the input clock level and all inputs
// synchronously to i_clock, one cycle per input-clock half period.
`timescale 1ns/1ps

module burst4_memory
  import burst4_pkg::*;
(
  input  wire logic             i_clock,        // Half-period clock
  input  wire logic             i_rst_b,        // Async reset, active low
  input  wire logic             i_clk_en,       // Freezes all state when low
  burst4_link_if.memory         link,           // Pins toward the controller
  output logic                  o_dll_active,   // Delay loop running
  output logic                  o_read_active   // Read burst on the bus
);
  import burst4_pkg::*;

  // Whole module state, including the storage array
  typedef struct packed {
    logic                          skip;         // Ignore next input-clock edge
    logic                          rd_pend;      // Read waiting in pipeline
    logic [1:0]                    rd_wait;      // Half periods left to wait
    logic [ADDR_W-1:0]             rd_pend_base; // Base of waiting read
    send_state_t                   send_st;      // Read send engine
    logic [ADDR_W-1:0]             send_base;    // Base of burst being sent
    logic [BEAT_W-1:0]             send_beat;    // Next beat to send
    logic                          wr_pend;      // Write waiting for data
    logic [ADDR_W-1:0]             wr_pend_base; // Base of waiting write
    logic                          wr_act;       // Write beats being taken
    logic [ADDR_W-1:0]             wr_base;      // Base of active write
    logic [BEAT_W-1:0]             wr_beat;      // Next beat to take
    logic [DATA_W-1:0]             dq;           // Output data register
    logic                          dq_oe;        // Output drivers on
    logic                          echo;         // Echo clock register
    logic                          dll_on;       // Delay loop state
    logic [WORDS-1:0][DATA_W-1:0]  mem;          // Storage array
  } mem_state_t;

  mem_state_t q;                                 // Registered state
  mem_state_t d;                                 // Next state

  logic k_edge;                                  // This cycle ends at a true-clock edge
  logic take;                                    // Command accepted at this edge
  logic fire;                                    // Output register fires at this edge
  logic [ADDR_W-1:0] base;                       // Address as the array sees it
  logic [ADDR_W-1:0] widx;                       // Word written this edge

  // Decode of the sampled pins
  always_comb begin
    k_edge = link.input_clock;
    take   = k_edge && !q.skip && !link.load_command_n;
    // Held-high output clocks hand the output register to the input clocks
    fire   = link.out_clk_hold_high ? 1'b1 : link.out_clk_fire;
    base   = link.sync_address_bus;
    if (NARROW_VARIANT) begin
      base[BEAT_W-1:0] = '0;
    end
    widx   = beat_addr(q.wr_base, q.wr_beat);
  end

  // Next-state logic
  always_comb begin
    d        = q;
    d.echo   = k_edge;                          // Echo follows the input clock
    d.dll_on = link.loop_disable_n;

    // Command capture only on true-clock edges
    if (k_edge) begin
      d.skip = take;
    end

    // Pipelined read wait
    if (q.rd_pend && q.rd_wait != 2'h0) begin
      d.rd_wait = q.rd_wait - 2'h1;
    end

    // Read send engine: one beat per output edge
    case (q.send_st)
      SEND_IDLE: begin
        if (fire) begin
          d.dq_oe = 1'b0;
        end
      end
      SEND_BURST: begin
        if (fire) begin
          d.dq        = q.mem[beat_addr(q.send_base, q.send_beat)];
          d.dq_oe     = 1'b1;
          d.send_beat = q.send_beat + 1'b1;
          if (q.send_beat == BEAT_W'(BEATS - 1)) begin
            d.send_st = SEND_IDLE;
          end
        end
      end
      default: begin
        d.send_st = SEND_IDLE;
        d.dq_oe   = 1'b0;
      end
    endcase

    // Promote waited read; a burst ending this edge hands over seamlessly
    if (q.rd_pend && q.rd_wait == 2'h0) begin
      d.rd_pend   = 1'b0;
      d.send_st   = SEND_BURST;
      d.send_base = q.rd_pend_base;
      d.send_beat = '0;
    end

    // Late-write collection, one beat per half period
    if (q.wr_act) begin
      for (int l = 0; l < LANES; l++) begin
        if (!link.byte_lane_enable_n[l]) begin
          d.mem[widx][l*LANE_W +: LANE_W] = link.dq_bus[l*LANE_W +: LANE_W];
        end
        // Masked lane keeps its stored byte
      end
      d.wr_beat = q.wr_beat + 1'b1;
      if (q.wr_beat == BEAT_W'(BEATS - 1)) begin
        d.wr_act = 1'b0;
      end
    end

    // Waiting write starts taking data after one half period
    if (q.wr_pend) begin
      d.wr_pend = 1'b0;
      d.wr_act  = 1'b1;
      d.wr_base = q.wr_pend_base;
      d.wr_beat = '0;
    end

    // New command enters its pipeline
    if (take) begin
      if (link.read_not_write) begin
        d.rd_pend      = 1'b1;
        d.rd_wait      = READ_WAIT_INIT;
        d.rd_pend_base = base;
      end else begin
        d.wr_pend      = 1'b1;
        d.wr_pend_base = base;
      end
    end
  end

  // State register; reset clears both the control state and the storage array
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q.skip         <= 1'b0;
      q.rd_pend      <= 1'b0;
      q.rd_wait      <= 2'h0;
      q.rd_pend_base <= '0;
      q.send_st      <= SEND_IDLE;
      q.send_base    <= '0;
      q.send_beat    <= '0;
      q.wr_pend      <= 1'b0;
      q.wr_pend_base <= '0;
      q.wr_act       <= 1'b0;
      q.wr_base      <= '0;
      q.wr_beat      <= '0;
      q.dq           <= DQ_RESET;
      q.dq_oe        <= 1'b0;
      q.echo         <= 1'b0;
      q.dll_on       <= 1'b0;
      q.mem          <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign link.dq_mem         = q.dq;
  assign link.dq_mem_oe      = q.dq_oe;
  assign link.echo_clock_out = q.echo;
  assign o_dll_active        = q.dll_on;
  assign o_read_active       = q.dq_oe;

endmodule

/* burst4_controller.sv */
// Controller end of the burst-of-four link: makes the input clock by halving,
// issues one command at a time and moves four beats per request.
// Assumes the memory shares i_clock and answers with its data enable.
`timescale 1ns/1ps
module burst4_controller
  import burst4_pkg::*;
(
  input  wire logic                          i_clock,          // Half-period clock
  input  wire logic                          i_rst_b,          // Async reset, active low
  input  wire logic                          i_clk_en,         // Freezes all state when low
  input  wire logic                          i_req_valid,      // Request present
  input  wire logic                          i_req_read,       // High read, low write
  input  wire logic [ADDR_W-1:0]             i_req_addr,       // Burst base address
  input  wire logic [BEATS*DATA_W-1:0]       i_wr_data,        // Beat 0 in low bits
  input  wire logic [BEATS*LANES-1:0]        i_wr_lane_en_n,   // Lane masks, beat 0 low
  input  wire logic                          i_use_out_clocks, // Drive output clocks
  input  wire logic                          i_loop_disable_n, // Loop disable request
  burst4_link_if.controller                  link,             // Pins toward the memory
  output logic                               o_req_ready,      // Request taken this cycle
  output logic [BEATS*DATA_W-1:0]            o_rd_data,        // Read burst, beat 0 low
  output logic                               o_rd_valid        // Read burst complete
);
  import burst4_pkg::*;

  // Whole module state
  typedef struct packed {
    ctl_state_t                   st;        // Sequencer
    logic                         k;         // Input clock level
    logic                         load_n;    // Load command pin
    logic                         rnw;       // Read-not-write pin
    logic [ADDR_W-1:0]            addr;      // Address pins
    logic [DATA_W-1:0]            dq;        // Write data pins
    logic                         dq_oe;     // Drive the bus
    logic [LANES-1:0]             lane_n;    // Lane enable pins
    logic [2:0]                   cnt;       // Beat counter
    logic [BEATS*DATA_W-1:0]      wdata;     // Held write burst
    logic [BEATS*LANES-1:0]       wlane;     // Held lane masks
    logic [BEATS*DATA_W-1:0]      rdata;     // Gathered read burst
    logic                         rd_valid;  // Read complete pulse
    logic                         ready;     // Ready to take a request
    logic                         hold_high; // Output clocks held high
    logic                         fire;      // Output clock strobe
    logic                         loop_n;    // Loop disable pin
  } ctl_reg_t;

  ctl_reg_t q;  // Registered state
  ctl_reg_t d;  // Next state

  // Next-state logic
  always_comb begin
    d           = q;
    d.k         = !q.k;                      // Divider makes the input clock
    d.rd_valid  = 1'b0;
    d.hold_high = !i_use_out_clocks;
    d.fire      = i_use_out_clocks;
    d.loop_n    = i_loop_disable_n;

    case (q.st)
      CTL_IDLE: begin
        // Accept only when the next half is a true-clock half
        if (q.ready && i_req_valid) begin
          d.st     = CTL_CMD;
          d.load_n = 1'b0;
          d.rnw    = i_req_read;
          d.addr   = i_req_addr;
          d.wdata  = i_wr_data;
          d.wlane  = i_wr_lane_en_n;
        end
      end
      CTL_CMD: begin
        // Command seen by the memory at this edge
        d.load_n = 1'b1;
        d.cnt    = 3'h0;
        d.st     = q.rnw ? CTL_RWAIT : CTL_WBEAT;
      end
      CTL_WBEAT: begin
        if (q.cnt != 3'(BEATS)) begin
          d.dq     = q.wdata[q.cnt[1:0]*DATA_W +: DATA_W];
          d.lane_n = q.wlane[q.cnt[1:0]*LANES +: LANES];
          d.dq_oe  = 1'b1;
          d.cnt    = q.cnt + 3'h1;
        end else begin
          d.dq_oe  = 1'b0;
          d.lane_n = LANES_OFF;
          d.st     = CTL_IDLE;
        end
      end
      CTL_RWAIT: begin
        // Gather beats while the memory drives
        if (link.dq_mem_oe) begin
          d.rdata[q.cnt[1:0]*DATA_W +: DATA_W] = link.dq_bus;
          d.cnt = q.cnt + 3'h1;
          if (q.cnt == 3'(BEATS - 1)) begin
            d.rd_valid = 1'b1;
            d.st       = CTL_IDLE;
          end
        end
      end
      default: begin
        d.st = CTL_IDLE;
      end
    endcase

    // Ready only in the half before a true-clock half
    d.ready = (d.st == CTL_IDLE) && !d.k && !(q.ready && i_req_valid);
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q.st        <= CTL_IDLE;
      q.k         <= 1'b0;
      q.load_n    <= 1'b1;
      q.rnw       <= 1'b1;
      q.addr      <= '0;
      q.dq        <= DQ_RESET;
      q.dq_oe     <= 1'b0;
      q.lane_n    <= LANES_OFF;
      q.cnt       <= 3'h0;
      q.wdata     <= '0;
      q.wlane     <= '1;
      q.rdata     <= '0;
      q.rd_valid  <= 1'b0;
      q.ready     <= 1'b0;
      q.hold_high <= 1'b1;
      q.fire      <= 1'b0;
      q.loop_n    <= 1'b0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Pins and user outputs from the state register
  assign link.input_clock        = q.k;
  assign link.out_clk_hold_high  = q.hold_high;
  assign link.out_clk_fire       = q.fire;
  assign link.load_command_n     = q.load_n;
  assign link.read_not_write     = q.rnw;
  assign link.sync_address_bus   = q.addr;
  assign link.byte_lane_enable_n = q.lane_n;
  assign link.loop_disable_n     = q.loop_n;
  assign link.dq_ctrl            = q.dq;
  assign link.dq_ctrl_oe         = q.dq_oe;
  assign o_req_ready             = q.ready;
  assign o_rd_data               = q.rdata;
  assign o_rd_valid              = q.rd_valid;

endmodule

/* burst4_link_props.sv */
// Checker for the burst-of-four link, watching the shared interface signals.
// Assumes both ends share i_clock and the controller keeps one command in flight.
`timescale 1ns/1ps
module burst4_link_props
  import burst4_pkg::*;
(
  input wire logic             i_clock,            // System clock
  input wire logic             i_rst_b,            // Async reset, active low
  input wire logic             input_clock,        // Input clock level
  input wire logic             out_clk_hold_high,  // Output clocks held high
  input wire logic             load_command_n,     // Load command, active low
  input wire logic             read_not_write,     // High read, low write
  input wire logic [LANES-1:0] byte_lane_enable_n, // Lane enables, active low
  input wire logic             dq_ctrl_oe,         // Controller drives bus
  input wire logic             dq_mem_oe           // Memory drives bus
);
  import burst4_pkg::*;

  // Command seen at the true edge ending this cycle
  logic rd_cap;
  logic wr_cap;
  assign rd_cap = input_clock && !load_command_n && read_not_write;
  assign wr_cap = input_clock && !load_command_n && !read_not_write;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Commands only in the true half
  property p_cmd_true;
    !load_command_n |-> input_clock;
  endproperty
  a_cmd_true: assert property (p_cmd_true) else $error("load outside true half");

  // Loads at least two input-clock cycles apart
  property p_load_gap;
    !load_command_n |=> load_command_n [*3];
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("loads too close");

  // First read beat after three idle edges
  property p_rd_first;
    rd_cap && out_clk_hold_high |=> !dq_mem_oe [*3] ##1 dq_mem_oe;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("read first beat late or early");

  // Exactly four beats, then high impedance
  property p_rd_beats;
    $rose(dq_mem_oe) && out_clk_hold_high |-> dq_mem_oe [*4] ##1 !dq_mem_oe;
  endproperty
  a_rd_beats: assert property (p_rd_beats) else $error("read burst not four beats");

  // Memory drives only for a captured read
  property p_rd_cause;
    $rose(dq_mem_oe) && out_clk_hold_high |-> $past(rd_cap, 4);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("bus driven without read");

  // Late write: one gap edge, then four beats
  property p_wr_beats;
    wr_cap |=> !dq_ctrl_oe ##1 dq_ctrl_oe [*4] ##1 !dq_ctrl_oe;
  endproperty
  a_wr_beats: assert property (p_wr_beats) else $error("write beats misplaced");

  // Never both sides on the bus
  property p_no_fight;
    !(dq_ctrl_oe && dq_mem_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus contention");

  // Lane enables only active with write data
  property p_lanes_idle;
    !dq_ctrl_oe |-> byte_lane_enable_n == LANES_OFF;
  endproperty
  a_lanes_idle: assert property (p_lanes_idle) else $error("lane enable outside write beat");
endmodule

/* tb.sv */
// Testbench joining controller and memory over the link interface.
// Assumes one 40 MHz clock; a reference array predicts every read.
`timescale 1ns/1ps
module tb;
  import burst4_pkg::*;

  logic                       i_clock;      // System clock
  logic                       i_rst_b;      // Reset, active low
  logic                       req_valid;    // Request present
  logic                       req_read;     // High read
  logic [ADDR_W-1:0]          req_addr;     // Base address
  logic [BEATS*DATA_W-1:0]    wr_data;      // Write burst
  logic [BEATS*LANES-1:0]     lane_n;       // Lane masks
  logic                       use_oc;       // Output clocks in use
  logic                       loop_dis_n;   // Loop disable, active low
  logic                       o_req_ready;  // Request taken
  logic [BEATS*DATA_W-1:0]    o_rd_data;    // Read burst
  logic                       o_rd_valid;   // Read done
  logic                       o_dll_active; // Loop running
  logic                       o_read_active;// Memory on bus
  logic [DATA_W-1:0]          ref_mem [WORDS]; // Expected array contents
  int                         n_mismatch;   // Failed compares
  int                         checks_done;  // All compares
  // Mask table: full, example pattern, abort, mixed
  localparam logic [7:0]      MASKS [5] = '{8'h00, 8'h46, 8'hff, 8'h9c, 8'h63};

  burst4_link_if link();

  burst4_memory i_burst4_memory (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(1'b1), .link(link),
    .o_dll_active(o_dll_active), .o_read_active(o_read_active));

  burst4_controller i_burst4_controller (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(1'b1),
    .i_req_valid(req_valid), .i_req_read(req_read), .i_req_addr(req_addr), .i_wr_data(wr_data),
    .i_wr_lane_en_n(lane_n), .i_use_out_clocks(use_oc), .i_loop_disable_n(loop_dis_n), .link(link),
    .o_req_ready(o_req_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid));

  burst4_link_props i_burst4_link_props (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .input_clock(link.input_clock), .out_clk_hold_high(link.out_clk_hold_high),
    .load_command_n(link.load_command_n), .read_not_write(link.read_not_write),
    .byte_lane_enable_n(link.byte_lane_enable_n), .dq_ctrl_oe(link.dq_ctrl_oe), .dq_mem_oe(link.dq_mem_oe));

  // Free-running clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // Word of beat b; base low bits wrap within four
  function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a, input int b);
    return {a[ADDR_W-1:2], 2'(int'(a[1:0]) + b)};
  endfunction

  task automatic chk_data(input logic [BEATS*DATA_W-1:0] got, input logic [BEATS*DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Hold request until taken; ready looked at mid-cycle to avoid edge races
  task automatic send(input logic rd, input logic [ADDR_W-1:0] a, input logic [BEATS*DATA_W-1:0] d,
                      input logic [BEATS*LANES-1:0] ln);
    int n;
    n = 0;
    @(posedge i_clock);
    req_valid <= 1'b1;
    req_read  <= rd;
    req_addr  <= a;
    wr_data   <= d;
    lane_n    <= ln;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_req_ready !== 1'b1 && n < 40);
    chk_bit(o_req_ready, 1'b1);
    @(posedge i_clock);
    req_valid <= 1'b0;
  endtask

  // Write burst and mirror enabled lanes into the reference
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [BEATS*DATA_W-1:0] d,
                             input logic [BEATS*LANES-1:0] ln);
    send(1'b0, a, d, ln);
    for (int b = 0; b < BEATS; b++) begin
      for (int l = 0; l < LANES; l++) begin
        // High enable leaves the stored lane alone
        if (!ln[b*LANES+l]) begin
          ref_mem[word_of(a, b)][l*LANE_W +: LANE_W] = d[b*DATA_W + l*LANE_W +: LANE_W];
        end
      end
    end
  endtask

  // Read burst, compare data, beats on the bus and, with input-clock timing, the latency
  task automatic read_check(input logic [ADDR_W-1:0] a);
    int n;
    int act;
    logic [BEATS*DATA_W-1:0] exp;
    n   = 0;
    act = 0;
    for (int b = 0; b < BEATS; b++) begin
      exp[b*DATA_W +: DATA_W] = ref_mem[word_of(a, b)];
    end
    send(1'b1, a, '0, '1);
    do begin
      @(negedge i_clock);
      n++;
      // Memory drive seen mid-cycle, one count per beat; a late release adds one
      if (o_read_active === 1'b1) begin
        act++;
      end
    end while (o_rd_valid !== 1'b1 && n < 40);
    chk_data(o_rd_data, exp);
    chk_num(act, BEATS);
    if (use_oc === 1'b0) begin
      // Capture one edge after take, first beat three later, four beats, one gather register
      chk_num(n, 1 + 3 + BEATS + 1);
    end
    // Return on a rising edge so later pin changes land there
    @(posedge i_clock);
  endtask

  task automatic tally_and_finish();
    $display("Checks done %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge i_clock);
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    i_rst_b     = 1'b0;
    req_valid   = 1'b0;
    req_read    = 1'b0;
    req_addr    = '0;
    wr_data     = '0;
    lane_n      = '1;
    use_oc      = 1'b0;
    loop_dis_n  = 1'b1;
    foreach (ref_mem[i]) ref_mem[i] = '0;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    // Cleared array reads zero
    read_check(6'h00);
    // Every mask pattern, each read back
    foreach (MASKS[k]) begin
      write_burst(6'h08, {18'h3c0f0 + 18'(k), 18'h0f3c3 + 18'(k), 18'h2a955 + 18'(k), 18'h1556a + 18'(k)},
                  MASKS[k]);
      read_check(6'h08);
    end
    // Unaligned base wraps within its group of four
    write_burst(6'h0e, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00);
    read_check(6'h0c);
    read_check(6'h0e);
    // Back-to-back commands at the tightest spacing
    write_burst(6'h3c, {4{18'h2d2d2}}, 8'h00);
    write_burst(6'h3d, {4{18'h1e1e1}}, 8'h30);
    read_check(6'h3c);
    // Output clocks in use instead of input-clock timing
    use_oc <= 1'b1;
    read_check(6'h3d);
    use_oc <= 1'b0;
    read_check(6'h3d);
    // Loop disable follows the pin
    loop_dis_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    chk_bit(o_dll_active, 1'b0);
    loop_dis_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk_bit(o_dll_active, 1'b1);
    tally_and_finish();
  end
endmodule
